/* rtl/radio_pm_defines.svh */
// Register map, field codes and reset values of the radio power-mode block
`ifndef RADIO_PM_DEFINES_SVH
`define RADIO_PM_DEFINES_SVH

`define RPM_ADDR_W 8
`define RPM_DATA_W 8
// Register offsets
`define RPM_OFS_POWER_MODE 8'h00
`define RPM_OFS_GAIN_COUNT 8'h01
`define RPM_OFS_AMPLITUDE 8'h02
`define RPM_OFS_FREQ_LO 8'h03
`define RPM_OFS_FREQ_HI 8'h04
`define RPM_OFS_REG_STATUS 8'h05
`define RPM_OFS_MODULATION 8'h06
`define RPM_OFS_OVERSAMPLE 8'h07
// Regulator status bit positions
`define RPM_BIT_ABOVE_1V3 0
`define RPM_BIT_ABOVE_2V3 1
`define RPM_BIT_STICKY_1V3 2
`define RPM_BIT_STICKY_2V3 3
// Field positions inside register data and the synchroniser bundle
`define RPM_MODE_MSB 3
`define RPM_MODSEL_MSB 1
`define RPM_SYNC_POS_2V3 0
`define RPM_SYNC_POS_1V3 1
`define RPM_SYNC_POS_FREQ 2
// Reset values, and the unity multiplier read back for non-FSK oversample
`define RPM_RST_OVERSAMPLE 8'h01
`define RPM_UNITY_MULT 8'h01
`define RPM_ZERO_BYTE 8'h00
// Modulator bitrate ceilings in kbit/s, for software reference
`define RPM_MAX_KBPS_ASK_PSK 600
`define RPM_MAX_KBPS_FSK_MSK 350
// Input widths
`define RPM_GAIN_W 8
`define RPM_AMPL_W 8
`define RPM_FREQ_W 16
`endif

/* rtl/radio_pm_pkg.sv */
// Types of the radio power-mode block
package radio_pm_pkg;
	typedef enum logic [3:0] {
		mode_off_low_leak = 4'b0000,
		mode_regulator_nominal = 4'b0100,
		mode_standby = 4'b0101,
		mode_synth_receive = 4'b1000,
		mode_receive_active = 4'b1001,
		mode_synth_transmit = 4'b1100,
		mode_transmit_active = 4'b1101
	} power_mode_e;

	typedef enum logic [1:0] {
		reg_low = 2'b00,
		reg_ramp = 2'b01,
		reg_ready = 2'b10
	} reg_state_e;

	typedef enum logic [1:0] {
		mod_ask = 2'b00,
		mod_fsk = 2'b01,
		mod_msk = 2'b10,
		mod_psk = 2'b11
	} modulation_e;

	typedef struct packed {
		power_mode_e mode;
		reg_state_e regst;
		modulation_e modsel;
		logic [7:0] oversample;
		logic sticky_1v3;
		logic sticky_2v3;
		logic [7:0] freq_hi_shadow;
		logic [7:0] gain_prev;
		logic [7:0] ampl_prev;
		logic [15:0] freq_prev;
		logic [7:0] gain_held;
		logic [7:0] ampl_held;
		logic [15:0] freq_held;
		logic [7:0] rdata;
		logic radio_regulator_status_nominal;
		logic xtal_en;
		logic synth_en;
		logic synth_tx_freq;
		logic rx_en;
		logic tx_en;
		logic pa_on;
		logic dev_positive;
		logic phase_flip;
	} ctl_s;
endpackage

/* rtl/sync_bits.sv */
// Two-stage synchroniser for a group of level inputs
module sync_bits #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	// Each bit gets its own pair of flops; first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				meta_reg[i] <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta_reg[i] <= async_in[i];
				sync_out[i] <= meta_reg[i];
			end
		end
	end
endmodule // sync_bits

/* rtl/bit_mapper.sv */
// Binary modulator bit mapping onto amplifier, deviation and phase controls
module bit_mapper (
	input wire radio_pm_pkg::modulation_e modsel,
	input wire logic tx_bit,
	input wire logic tx_active,
	output logic pa_on,
	output logic dev_positive,
	output logic phase_flip
);
	// One bit per symbol: each scheme picks one of only two states
	always_comb begin
		pa_on = tx_active;
		dev_positive = 1'b0;
		phase_flip = 1'b0;
		case (modsel)
			radio_pm_pkg::mod_ask: begin
				pa_on = tx_active & tx_bit;
			end
			radio_pm_pkg::mod_fsk, radio_pm_pkg::mod_msk: begin
				dev_positive = tx_bit;
			end
			radio_pm_pkg::mod_psk: begin
				phase_flip = tx_bit;
			end
			default: begin
				pa_on = 1'b0;
			end
		endcase
	end
endmodule // bit_mapper

/* rtl/radio_power_mode_control.sv */
// Transceiver power-mode sequencer with signal strength and tracking readouts
//
// Implementation choices: the address map and the plain strobed port.
`include "radio_pm_defines.svh"

module radio_power_mode_control (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] gain_control_count,
	input wire logic [7:0] tracked_amplitude,
	input wire logic [15:0] freq_track_value,
	input wire logic radio_regulator_status_above_1v3,
	input wire logic radio_regulator_status_above_2v3,
	input wire logic tx_bit,
	output logic radio_regulator_status_nominal,
	output logic xtal_en,
	output logic synth_en,
	output logic synth_tx_freq,
	output logic rx_en,
	output logic tx_en,
	output logic pa_on,
	output logic dev_positive,
	output logic phase_flip
);
	localparam int SYNC_W = `RPM_GAIN_W + `RPM_AMPL_W + `RPM_FREQ_W + 2;

	radio_pm_pkg::ctl_s state_reg;
	radio_pm_pkg::ctl_s state_next;

	logic [SYNC_W-1:0] sync_raw;
	logic [SYNC_W-1:0] sync_val;
	logic [7:0] gain_s;
	logic [7:0] ampl_s;
	logic [15:0] freq_s;
	logic above_1v3_s;
	logic above_2v3_s;
	logic map_pa_on;
	logic map_dev_pos;
	logic map_phase_flip;

	// Analog-side readouts arrive from outside the clock domain
	// Bundled into one vector so a single synchroniser instance serves all
	assign sync_raw = {gain_control_count, tracked_amplitude, freq_track_value,
		radio_regulator_status_above_1v3, radio_regulator_status_above_2v3};

	sync_bits #(
		.W(SYNC_W)
	) u_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.async_in(sync_raw),
		.sync_out(sync_val)
	);

	// Bits are synced one by one, so these words may be torn for a cycle;
	// the agreement check in the next-value process hides that from reads
	assign gain_s = sync_val[SYNC_W-1 -: `RPM_GAIN_W];
	assign ampl_s = sync_val[SYNC_W-1-`RPM_GAIN_W -: `RPM_AMPL_W];
	assign freq_s = sync_val[`RPM_SYNC_POS_FREQ +: `RPM_FREQ_W];
	assign above_1v3_s = sync_val[`RPM_SYNC_POS_1V3];
	assign above_2v3_s = sync_val[`RPM_SYNC_POS_2V3];

	// Bit mapping runs in every mode, only pa_on is gated by transmit; result is registered below
	bit_mapper u_map (
		.modsel(state_reg.modsel),
		.tx_bit(tx_bit),
		.tx_active(state_reg.tx_en),
		.pa_on(map_pa_on),
		.dev_positive(map_dev_pos),
		.phase_flip(map_phase_flip)
	);

	// Whole control state in one next-value process
	always_comb begin
		logic mode_ok;
		logic leave_tx_bad;
		logic need_reg;
		logic reg_good;
		logic [7:0] rd_val;
		radio_pm_pkg::power_mode_e req;
		mode_ok = 1'b0;
		leave_tx_bad = 1'b0;
		need_reg = 1'b0;
		reg_good = 1'b0;
		rd_val = `RPM_ZERO_BYTE;
		req = radio_pm_pkg::power_mode_e'(reg_wdata[`RPM_MODE_MSB:0]);
		state_next = state_reg;

		// Mode write: only this field steers power, nothing else does
		case (reg_wdata[`RPM_MODE_MSB:0])
			radio_pm_pkg::mode_off_low_leak, radio_pm_pkg::mode_regulator_nominal,
			radio_pm_pkg::mode_standby, radio_pm_pkg::mode_synth_receive,
			radio_pm_pkg::mode_receive_active, radio_pm_pkg::mode_synth_transmit,
			radio_pm_pkg::mode_transmit_active: begin
				mode_ok = 1'b1;
			end
			default: begin
				mode_ok = 1'b0;
			end
		endcase
		// Dropping out of full transmit to standby or below must pass through synth-transmit, synth-receive or receive-active
		// The refusal is silent; software sees it only by reading the mode back
		if (state_reg.mode == radio_pm_pkg::mode_transmit_active &&
			(req == radio_pm_pkg::mode_off_low_leak ||
			req == radio_pm_pkg::mode_regulator_nominal ||
			req == radio_pm_pkg::mode_standby)) begin
			leave_tx_bad = 1'b1;
		end
		if (reg_wr && reg_addr == `RPM_OFS_POWER_MODE && mode_ok && !leave_tx_bad) begin
			state_next.mode = req;
		end
		// Other writable registers remain live in every power mode
		if (reg_wr && reg_addr == `RPM_OFS_MODULATION) begin
			state_next.modsel = radio_pm_pkg::modulation_e'(reg_wdata[`RPM_MODSEL_MSB:0]);
		end
		if (reg_wr && reg_addr == `RPM_OFS_OVERSAMPLE) begin
			state_next.oversample = reg_wdata;
		end

		// Regulator sequencing: any mode above power-down needs it nominal
		// A regulator stuck below 2.3 V holds ramp, so no radio part is enabled
		need_reg = (state_next.mode != radio_pm_pkg::mode_off_low_leak);
		case (state_reg.regst)
			radio_pm_pkg::reg_low: begin
				if (need_reg) begin
					state_next.regst = radio_pm_pkg::reg_ramp;
				end
			end
			radio_pm_pkg::reg_ramp: begin
				if (!need_reg) begin
					state_next.regst = radio_pm_pkg::reg_low;
				end else if (above_2v3_s) begin
					state_next.regst = radio_pm_pkg::reg_ready;
				end
			end
			radio_pm_pkg::reg_ready: begin
				if (!need_reg) begin
					state_next.regst = radio_pm_pkg::reg_low;
				end
			end
			default: begin
				state_next.regst = radio_pm_pkg::reg_low;
			end
		endcase
		reg_good = (state_next.regst == radio_pm_pkg::reg_ready);

		// Block enables decoded from the mode; radio parts wait for the regulator
		state_next.radio_regulator_status_nominal = need_reg;
		state_next.xtal_en = 1'b0;
		state_next.synth_en = 1'b0;
		state_next.synth_tx_freq = 1'b0;
		state_next.rx_en = 1'b0;
		state_next.tx_en = 1'b0;
		case (state_next.mode)
			radio_pm_pkg::mode_standby: begin
				state_next.xtal_en = reg_good;
			end
			radio_pm_pkg::mode_synth_receive: begin
				state_next.xtal_en = reg_good;
				state_next.synth_en = reg_good;
			end
			radio_pm_pkg::mode_receive_active: begin
				state_next.xtal_en = reg_good;
				state_next.synth_en = reg_good;
				state_next.rx_en = reg_good;
			end
			radio_pm_pkg::mode_synth_transmit: begin
				state_next.xtal_en = reg_good;
				state_next.synth_en = reg_good;
				state_next.synth_tx_freq = 1'b1;
			end
			radio_pm_pkg::mode_transmit_active: begin
				state_next.xtal_en = reg_good;
				state_next.synth_en = reg_good;
				state_next.synth_tx_freq = 1'b1;
				state_next.tx_en = reg_good;
			end
			radio_pm_pkg::mode_off_low_leak: begin
				state_next.xtal_en = 1'b0;
			end
			radio_pm_pkg::mode_regulator_nominal: begin
				state_next.xtal_en = 1'b0;
			end
			default: begin
				state_next.xtal_en = 1'b0;
			end
		endcase

		// Modulator controls follow the mapper, registered for clean outputs
		state_next.pa_on = map_pa_on;
		state_next.dev_positive = map_dev_pos;
		state_next.phase_flip = map_phase_flip;

		// A readout word is taken only when two synced samples agree, so a word
		// caught mid-change never reaches a read; a word moving every cycle waits
		state_next.gain_prev = gain_s;
		if (gain_s == state_reg.gain_prev) begin
			state_next.gain_held = gain_s;
		end
		state_next.ampl_prev = ampl_s;
		if (ampl_s == state_reg.ampl_prev) begin
			state_next.ampl_held = ampl_s;
		end
		state_next.freq_prev = freq_s;
		if (freq_s == state_reg.freq_prev) begin
			state_next.freq_held = freq_s;
		end

		// Sticky low-voltage flags; a fresh event beats a clear in the same cycle
		if (reg_wr && reg_addr == `RPM_OFS_REG_STATUS) begin
			if (reg_wdata[`RPM_BIT_STICKY_1V3]) begin
				state_next.sticky_1v3 = 1'b0;
			end
			if (reg_wdata[`RPM_BIT_STICKY_2V3]) begin
				state_next.sticky_2v3 = 1'b0;
			end
		end
		if (!above_1v3_s) begin
			state_next.sticky_1v3 = 1'b1;
		end
		// Below 2.3 V is normal in power-down, so only a dip while ready counts
		if (!above_2v3_s && state_reg.regst == radio_pm_pkg::reg_ready) begin
			state_next.sticky_2v3 = 1'b1;
		end

		// Read mux; unmapped offsets return zero
		// Live flags come straight from the synchroniser, sticky ones from state
		case (reg_addr)
			`RPM_OFS_POWER_MODE: begin
				rd_val = {4'h0, state_reg.mode};
			end
			`RPM_OFS_GAIN_COUNT: begin
				rd_val = state_reg.gain_held;
			end
			`RPM_OFS_AMPLITUDE: begin
				rd_val = state_reg.ampl_held;
			end
			`RPM_OFS_FREQ_LO: begin
				rd_val = state_reg.freq_held[7:0];
			end
			`RPM_OFS_FREQ_HI: begin
				rd_val = state_reg.freq_hi_shadow;
			end
			`RPM_OFS_REG_STATUS: begin
				rd_val = `RPM_ZERO_BYTE;
				rd_val[`RPM_BIT_ABOVE_1V3] = above_1v3_s;
				rd_val[`RPM_BIT_ABOVE_2V3] = above_2v3_s;
				rd_val[`RPM_BIT_STICKY_1V3] = state_reg.sticky_1v3;
				rd_val[`RPM_BIT_STICKY_2V3] = state_reg.sticky_2v3;
			end
			`RPM_OFS_MODULATION: begin
				rd_val = {6'h00, state_reg.modsel};
			end
			`RPM_OFS_OVERSAMPLE: begin
				// Non-FSK offsets use a unity multiplier
				rd_val = (state_reg.modsel == radio_pm_pkg::mod_fsk) ?
					state_reg.oversample : `RPM_UNITY_MULT;
			end
			default: begin
				rd_val = `RPM_ZERO_BYTE;
			end
		endcase
		// Low-byte read freezes the high byte so the 16-bit pair is coherent
		if (reg_rd && reg_addr == `RPM_OFS_FREQ_LO) begin
			state_next.freq_hi_shadow = state_reg.freq_held[15:8];
		end
		state_next.rdata = reg_rd ? rd_val : `RPM_ZERO_BYTE;
	end

	// Single state register; reset lands in power-down with regulator low
	// Async reset loads constants only, never a value from logic
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg.mode <= radio_pm_pkg::mode_off_low_leak;
			state_reg.regst <= radio_pm_pkg::reg_low;
			state_reg.modsel <= radio_pm_pkg::mod_ask;
			state_reg.oversample <= `RPM_RST_OVERSAMPLE;
			state_reg.sticky_1v3 <= 1'b0;
			state_reg.sticky_2v3 <= 1'b0;
			state_reg.freq_hi_shadow <= `RPM_ZERO_BYTE;
			state_reg.gain_prev <= `RPM_ZERO_BYTE;
			state_reg.ampl_prev <= `RPM_ZERO_BYTE;
			state_reg.freq_prev <= {`RPM_ZERO_BYTE, `RPM_ZERO_BYTE};
			state_reg.gain_held <= `RPM_ZERO_BYTE;
			state_reg.ampl_held <= `RPM_ZERO_BYTE;
			state_reg.freq_held <= {`RPM_ZERO_BYTE, `RPM_ZERO_BYTE};
			state_reg.rdata <= `RPM_ZERO_BYTE;
			state_reg.radio_regulator_status_nominal <= 1'b0;
			state_reg.xtal_en <= 1'b0;
			state_reg.synth_en <= 1'b0;
			state_reg.synth_tx_freq <= 1'b0;
			state_reg.rx_en <= 1'b0;
			state_reg.tx_en <= 1'b0;
			state_reg.pa_on <= 1'b0;
			state_reg.dev_positive <= 1'b0;
			state_reg.phase_flip <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Read data straight from its flop
	assign reg_rdata = state_reg.rdata;

	// Power enables straight from the state flops
	assign radio_regulator_status_nominal = state_reg.radio_regulator_status_nominal;
	assign xtal_en = state_reg.xtal_en;
	assign synth_en = state_reg.synth_en;
	assign synth_tx_freq = state_reg.synth_tx_freq;
	assign rx_en = state_reg.rx_en;
	assign tx_en = state_reg.tx_en;

	// Modulator controls, already registered after the mapper
	assign pa_on = state_reg.pa_on;
	assign dev_positive = state_reg.dev_positive;
	assign phase_flip = state_reg.phase_flip;
endmodule // radio_power_mode_control

/* bench/rpm_properties.sv */
// Port-level properties of the radio power-mode controller
module rpm_properties (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic tx_bit,
	input wire logic radio_regulator_status_nominal,
	input wire logic xtal_en,
	input wire logic synth_en,
	input wire logic synth_tx_freq,
	input wire logic rx_en,
	input wire logic tx_en,
	input wire logic dev_positive,
	input wire logic phase_flip
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// Mode write outside the transmit modes, where some codes are refused
	sequence mode_wr(logic [7:0] c);
		reg_wr && reg_addr == 8'h00 && reg_wdata == c && !synth_tx_freq;
	endsequence
	sequence tx_leaves;
		$fell(tx_en);
	endsequence
	// Read data stands one cycle only
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	off_drops_all_a: assert property (mode_wr(8'h00) |=>
		!radio_regulator_status_nominal && !xtal_en && !synth_en && !rx_en && !tx_en)
		else $error("power-down left something on");
	nominal_on_a: assert property (mode_wr(8'h04) |=>
		radio_regulator_status_nominal && !xtal_en && !synth_en && !rx_en && !tx_en)
		else $error("regulator-on mode wrong");
	powered_off_a: assert property (!radio_regulator_status_nominal |->
		!(xtal_en || synth_en || rx_en || tx_en))
		else $error("enable without regulator");
	rx_path_a: assert property (rx_en |-> synth_en && !synth_tx_freq && !tx_en)
		else $error("receiver without receive synth");
	tx_path_a: assert property (tx_en |-> synth_en && synth_tx_freq && !rx_en)
		else $error("transmitter without transmit synth");
	tx_exit_a: assert property (tx_leaves |-> synth_en && synth_tx_freq && radio_regulator_status_nominal)
		else $error("transmit left other than to synth");
	tx_hold_a: assert property (tx_en && reg_wr && reg_addr == 8'h00
		&& reg_wdata < 8'h08 |=> tx_en)
		else $error("direct exit from transmit");
	dev_map_a: assert property (dev_positive |-> $past(tx_bit) && !phase_flip)
		else $error("deviation not from bit");
	phase_map_a: assert property (phase_flip |-> $past(tx_bit))
		else $error("phase flip not from bit");
endmodule // rpm_properties

bind radio_power_mode_control rpm_properties i_props (
	.mclk(mclk),
	.rst_b(rst_b),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.tx_bit(tx_bit),
	.radio_regulator_status_nominal(radio_regulator_status_nominal),
	.xtal_en(xtal_en),
	.synth_en(synth_en),
	.synth_tx_freq(synth_tx_freq),
	.rx_en(rx_en),
	.tx_en(tx_en),
	.dev_positive(dev_positive),
	.phase_flip(phase_flip)
);

/* bench/rpm_frontend_model.sv */
// Analog front-end stand-in: regulator ramp and brown-out dips
module rpm_frontend_model #(
	parameter int RAMP = 12
) (
	input wire logic mclk,
	input wire logic radio_regulator_status_nominal,
	input wire logic dip,
	output logic radio_regulator_status_above_1v3,
	output logic radio_regulator_status_above_2v3
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// Ramp only while requested; low level still sits above 1.3 V
	always @(posedge mclk) begin
		if (!radio_regulator_status_nominal) begin
			cnt <= 0;
		end else if (cnt < RAMP) begin
			cnt <= cnt + 1;
		end
	end
	// A dip is a brown-out through both thresholds
	assign radio_regulator_status_above_1v3 = !dip;
	assign radio_regulator_status_above_2v3 = (cnt == RAMP) && !dip;
endmodule // rpm_frontend_model

/* bench/radio_power_mode_control_tb_top.sv */
// Self-checking bench for the radio power-mode controller
module radio_power_mode_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_bit = 1'b0, dip = 1'b0;
	logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, gain = '0, ampl = '0;
	logic [15:0] freq = '0;
	logic radio_regulator_status_nominal, xtal_en, synth_en, synth_tx_freq, rx_en, tx_en, v13, v23;
	logic pa_on, dev_positive, phase_flip, rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h131ce387;
	int fail_count = 0, checked = 0;
	// Slowest synthesizer settle, 50 us at 100 MHz
	localparam int SYNTH_SETTLE = 5000;

	radio_power_mode_control i_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.gain_control_count(gain), .tracked_amplitude(ampl), .freq_track_value(freq),
		.radio_regulator_status_above_1v3(v13), .radio_regulator_status_above_2v3(v23), .tx_bit(tx_bit),
		.radio_regulator_status_nominal(radio_regulator_status_nominal), .xtal_en(xtal_en), .synth_en(synth_en),
		.synth_tx_freq(synth_tx_freq), .rx_en(rx_en), .tx_en(tx_en), .pa_on(pa_on),
		.dev_positive(dev_positive), .phase_flip(phase_flip));
	rpm_frontend_model i_fe (.mclk(mclk), .radio_regulator_status_nominal(radio_regulator_status_nominal), .dip(dip),
		.radio_regulator_status_above_1v3(v13), .radio_regulator_status_above_2v3(v23));

	always #5 mclk = ~mclk;

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checked++;
		if (seen !== want) begin
			fail_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// One strobe cycle; strobes drop at the sampling edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask
	// Enables {regulator, synth, tx freq, rx, tx} once the edge has landed
	task automatic en(input logic [4:0] e);
		@(negedge mclk);
		check({3'b000, radio_regulator_status_nominal, synth_en, synth_tx_freq, rx_en, tx_en}, {3'b000, e});
	endtask
	task automatic mode(input logic [7:0] m, input logic [4:0] e);
		bus(1'b1, 8'h00, m);
		en(e);
	endtask
	// Bounded wait: ramp of the model plus the input synchroniser
	task automatic wait_xtal();
		int i;
		for (i = 0; i < 40 && xtal_en !== 1'b1; i++) @(posedge mclk);
		@(negedge mclk);
		check({7'h00, xtal_en}, 8'h01);
	endtask

	// Read data matched against the oldest note
	always @(posedge mclk) rd_seen <= reg_rd;
	always @(negedge mclk) begin
		if (rd_seen && exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
	end

	initial begin
		int m, k;
		logic [7:0] pm_want;
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		// The synchroniser flush after reset leaves the 1.3 V sticky set
		repeat (2) @(posedge mclk);
		rd(8'h05, 8'h05);
		bus(1'b1, 8'h05, 8'h0c);
		rd(8'h00, 8'h00);
		rd(8'h07, 8'h01);
		rd(8'h05, 8'h01);
		rd(8'h3c, 8'h00);
		bus(1'b1, 8'h06, 8'h02);
		rd(8'h06, 8'h02);
		en(5'b00000);
		@(posedge mclk);
		seed = lfsr(seed);
		gain <= seed[7:0];
		ampl <= seed[15:8];
		freq <= seed[31:16];
		repeat (4) @(posedge mclk);
		rd(8'h01, gain);
		rd(8'h02, ampl);
		rd(8'h03, freq[7:0]);
		rd(8'h04, freq[15:8]);
		$display("test reset and readouts done");
		mode(8'h04, 5'b10000);
		bus(1'b1, 8'h00, 8'h05);
		wait_xtal();
		en(5'b10000);
		mode(8'h0c, 5'b11100);
		repeat (SYNTH_SETTLE) @(posedge mclk);
		mode(8'h0d, 5'b11101);
		mode(8'h00, 5'b11101);
		mode(8'h05, 5'b11101);
		rd(8'h00, 8'h0d);
		// Every scheme with random bits while transmitting
		for (m = 0; m < 4; m++) begin
			bus(1'b1, 8'h06, m[7:0]);
			bus(1'b1, 8'h07, 8'h05);
			rd(8'h07, (m == 1) ? 8'h05 : 8'h01);
			for (k = 0; k < 8; k++) begin
				@(posedge mclk);
				seed = lfsr(seed);
				tx_bit <= seed[0];
				@(posedge mclk);
				@(negedge mclk);
				pm_want = {5'h00, ((m == 0) ? seed[0] : 1'b1),
					(m == 1 || m == 2) && seed[0], (m == 3) && seed[0]};
				check({5'h00, pa_on, dev_positive, phase_flip}, pm_want);
			end
		end
		mode(8'h0c, 5'b11100);
		mode(8'h00, 5'b00000);
		rd(8'h00, 8'h00);
		$display("test transmit session done");
		bus(1'b1, 8'h00, 8'h05);
		wait_xtal();
		@(posedge mclk);
		dip <= 1'b1;
		repeat (6) @(posedge mclk);
		dip <= 1'b0;
		repeat (4) @(posedge mclk);
		rd(8'h05, 8'h0f);
		bus(1'b1, 8'h05, 8'h08);
		rd(8'h05, 8'h07);
		bus(1'b1, 8'h05, 8'h04);
		rd(8'h05, 8'h03);
		mode(8'h08, 5'b11000);
		repeat (SYNTH_SETTLE) @(posedge mclk);
		mode(8'h09, 5'b11010);
		bus(1'b1, 8'h00, 8'h03);
		rd(8'h00, 8'h09);
		mode(8'h00, 5'b00000);
		$display("test receive session done");
		summarize();
	end

	// Watchdog: two synthesizer settles plus register traffic, with wide margin
	initial begin
		#300us;
		fail_count++;
		summarize();
	end
endmodule // radio_power_mode_control_tb_top
